/* rtl/lpm_control.sv */
// Operation
// - Wait/stop instruction enters mode, CPU unclocked
// - Entering low power clears interrupt mask
// - Wait gates CPU clock, peripherals run
// - Enabled interrupt wakes wait, stacking next cycle
// - Reset or break also ends wait
// - Break exit sets break exit flag
// - Watchdog runs in wait unless disabled
// - Stop resets counter, stops all clocks
// - Interrupt, reset, break end stop; delayed stacking
// - Stop blocks base and crystal clock outputs
// - Recovery 4096 cycles, or 32 if short
// - Counter held in stop, then times recovery
// - Three registers at FE00, FE01, FE03
// - Break exit flag cleared by zero write, reset
// - Reading reset cause clears all flags
// - Power-on sets its flag, clears others
// - Pin, watchdog, opcode, USB cause flags
// - Illegal address flag only for opcode fetch
// - Break clear enable gates flag clearing in break; code gates only the reset cause read clear, not the break exit flag zero write
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lpm_control
    import lpm_pkg::*;
#(
    parameter int RECOVERY_LONG = lpm_pkg::LPM_RECOVERY_LONG,
    parameter int RECOVERY_SHORT = lpm_pkg::LPM_RECOVERY_SHORT
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic waitInstr,
    input wire logic stopInstr,
    input wire logic moduleIrq,
    input wire logic breakIrq,
    input wire logic inBreakState,
    input wire logic shortRecoverySelect,
    input wire logic watchdogDisableOption,
    input wire logic causeValid,
    input wire logic causePowerOn,
    input wire logic causePin,
    input wire logic causeWatchdog,
    input wire logic causeIllegalOpcode,
    input wire logic causeIllegalAddress,
    input wire logic causeAddressIsFetch,
    input wire logic causeUsb,
    output logic cpuClockEnable,
    output logic periphClockEnable,
    output logic baseClockEnable,
    output logic crystalClockEnable,
    output logic watchdogRun,
    output logic clearIntMask,
    output logic stackStart,
    output logic breakExitStatus,
    output logic breakClearAllowed
);
    import lpm_pkg::*;

    lpm_state_e state_r;
    lpm_state_e state_nxt;
    logic [LPM_COUNT_WIDTH-1:0] sysCount_r;
    logic [LPM_COUNT_WIDTH-1:0] recoveryTarget;
    logic breakExit_r;
    logic [7:0] resetCause_r;
    logic breakClearEnable_r;
    logic wakeIrq;
    logic wakeBreak;
    logic recoveryDone;
    logic apbWrite;
    logic apbRead;
    logic addrHit;

    // Wake sources shared by wait and stop
    assign wakeIrq = moduleIrq;
    assign wakeBreak = breakIrq;
    assign recoveryTarget = shortRecoverySelect ? LPM_COUNT_WIDTH'(RECOVERY_SHORT - 1)
                                                : LPM_COUNT_WIDTH'(RECOVERY_LONG - 1);
    assign recoveryDone = (sysCount_r == recoveryTarget);
    assign apbWrite = psel && penable && pwrite && pready;
    assign apbRead = psel && penable && !pwrite && pready;
    assign addrHit = (paddr == LPM_BREAK_STATUS_ADDR) || (paddr == LPM_RESET_CAUSE_ADDR)
                     || (paddr == LPM_BREAK_FLAG_CONTROL_ADDR);

    // Mode sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LPM_RUN: begin
                if (stopInstr) begin
                    state_nxt = LPM_STOP;
                end else if (waitInstr) begin
                    state_nxt = LPM_WAIT;
                end
            end
            LPM_WAIT: begin
                if (wakeIrq || wakeBreak) begin
                    state_nxt = LPM_RUN;
                end
            end
            LPM_STOP: begin
                if (wakeBreak) begin
                    state_nxt = LPM_RUN;
                end else if (wakeIrq) begin
                    state_nxt = LPM_RECOVER;
                end
            end
            LPM_RECOVER: begin
                if (wakeBreak || recoveryDone) begin
                    state_nxt = LPM_RUN;
                end
            end
            default: state_nxt = LPM_RUN;
        endcase
    end

    // State register; reset forces run
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= LPM_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // System counter held in stop, counts during recovery
    always_ff @(posedge mclk) begin
        if (reset || state_r != LPM_RECOVER) begin
            sysCount_r <= '0;
        end else begin
            sysCount_r <= sysCount_r + 1'b1;
        end
    end

    // Clock gating and control outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpuClockEnable <= 1'b1;
            periphClockEnable <= 1'b1;
            baseClockEnable <= 1'b1;
            crystalClockEnable <= 1'b1;
            watchdogRun <= 1'b0;
            clearIntMask <= 1'b0;
            stackStart <= 1'b0;
        end else begin
            cpuClockEnable <= (state_nxt == LPM_RUN);
            periphClockEnable <= (state_nxt == LPM_RUN) || (state_nxt == LPM_WAIT);
            baseClockEnable <= (state_nxt != LPM_STOP);
            crystalClockEnable <= (state_nxt != LPM_STOP);
            watchdogRun <= !watchdogDisableOption && (state_nxt != LPM_STOP) &&
                           (state_nxt != LPM_RECOVER);
            clearIntMask <= (state_r == LPM_RUN) && (stopInstr || waitInstr);
            stackStart <= ((state_r == LPM_WAIT) && wakeIrq && !wakeBreak) ||
                          ((state_r == LPM_RECOVER) && recoveryDone);
        end
    end

    // Break exit flag: set wins over software clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            breakExit_r <= LPM_BREAK_STATUS_RESET[LPM_BREAK_EXIT_BIT];
        end else if ((state_r == LPM_WAIT || state_r == LPM_STOP || state_r == LPM_RECOVER) && wakeBreak) begin
            breakExit_r <= 1'b1;
        end else if (apbWrite && paddr == LPM_BREAK_STATUS_ADDR && !pwdata[LPM_BREAK_EXIT_BIT]) begin
            breakExit_r <= 1'b0;
        end
    end

    // Reset cause: captured flags win over read clear
    always_ff @(posedge mclk) begin
        if (causeValid && causePowerOn) begin
            resetCause_r <= LPM_RESET_CAUSE_RESET;
        end else if (causeValid) begin
            resetCause_r <= 8'h00;
            resetCause_r[LPM_CAUSE_PIN_BIT] <= causePin;
            resetCause_r[LPM_CAUSE_WATCHDOG_BIT] <= causeWatchdog;
            resetCause_r[LPM_CAUSE_ILLEGAL_OPCODE_BIT] <= causeIllegalOpcode;
            resetCause_r[LPM_CAUSE_ILLEGAL_ADDRESS_BIT] <= causeIllegalAddress && causeAddressIsFetch;
            resetCause_r[LPM_CAUSE_USB_BIT] <= causeUsb;
        end else if (reset) begin
            resetCause_r <= resetCause_r;
        end else if (apbRead && paddr == LPM_RESET_CAUSE_ADDR && (!inBreakState || breakClearEnable_r)) begin
            resetCause_r <= 8'h00;
        end
    end

    // Break clear enable bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            breakClearEnable_r <= LPM_BREAK_FLAG_CONTROL_RESET[LPM_BREAK_CLEAR_ENABLE_BIT];
        end else if (apbWrite && paddr == LPM_BREAK_FLAG_CONTROL_ADDR) begin
            breakClearEnable_r <= pwdata[LPM_BREAK_CLEAR_ENABLE_BIT];
        end
    end

    // APB slave: one wait state, error on unmapped address
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addrHit;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    LPM_BREAK_STATUS_ADDR: prdata[LPM_BREAK_EXIT_BIT] <= breakExit_r;
                    LPM_RESET_CAUSE_ADDR: prdata[7:0] <= resetCause_r;
                    LPM_BREAK_FLAG_CONTROL_ADDR: prdata[LPM_BREAK_CLEAR_ENABLE_BIT] <= breakClearEnable_r;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Status outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            breakExitStatus <= 1'b0;
            breakClearAllowed <= 1'b0;
        end else begin
            breakExitStatus <= breakExit_r;
            breakClearAllowed <= !inBreakState || breakClearEnable_r;
        end
    end

    // Checks
    wait_clocks_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == LPM_WAIT |=> periphClockEnable && !cpuClockEnable || state_r != LPM_WAIT)
        else $error("wait clock gating wrong");
    stop_clocks_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RUN && stopInstr) |=> !baseClockEnable && !crystalClockEnable && !periphClockEnable)
        else $error("stop clocks not blocked");
    mask_clear_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RUN && waitInstr) |=> clearIntMask)
        else $error("interrupt mask not cleared");
    wait_wake_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_WAIT && moduleIrq && !breakIrq) |=> stackStart && cpuClockEnable)
        else $error("wait wake late");
    break_flag_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_STOP && breakIrq) |=> breakExit_r)
        else $error("break exit flag not set");
    counter_hold_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == LPM_STOP |-> sysCount_r == '0)
        else $error("counter not held");
    short_recover_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_STOP && moduleIrq && !breakIrq && shortRecoverySelect)
        ##1 (shortRecoverySelect && !breakIrq)[*8] |-> ##[1:40] stackStart)
        else $error("short recovery too long");
    cause_read_a: assert property (@(posedge mclk) disable iff (reset)
        (apbRead && paddr == LPM_RESET_CAUSE_ADDR && !inBreakState && !causeValid) |=> resetCause_r == 8'h00)
        else $error("cause not cleared by read");
    break_clear_enable_write_a: assert property (@(posedge mclk) disable iff (reset)
        (apbWrite && paddr == LPM_BREAK_FLAG_CONTROL_ADDR) |=> breakClearEnable_r == $past(pwdata[7]))
        else $error("break clear enable not written");

    wait_entry_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RUN && waitInstr && !stopInstr) |=> !cpuClockEnable && periphClockEnable)
        else $error("wait entry clocks wrong");

    stop_mask_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RUN && stopInstr) |=> clearIntMask)
        else $error("stop did not clear mask");

    wait_watchdog_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RUN && waitInstr && !stopInstr && !watchdogDisableOption) |=> watchdogRun)
        else $error("watchdog stopped in wait");

    wait_break_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_WAIT && breakIrq) |=> cpuClockEnable && !stackStart && breakExit_r)
        else $error("break did not end wait");

    stop_break_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_STOP && breakIrq) |=> state_r == LPM_RUN && cpuClockEnable)
        else $error("break did not end stop");

    stop_irq_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_STOP && moduleIrq && !breakIrq) |=> state_r == LPM_RECOVER && !cpuClockEnable
        && baseClockEnable)
        else $error("interrupt did not start recovery");

    count_run_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RECOVER && !recoveryDone && !breakIrq) |=> sysCount_r == $past(sysCount_r) + 1'b1)
        else $error("recovery counter stalled");

    count_clear_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == LPM_STOP |=> sysCount_r == '0)
        else $error("counter not reset in stop");

    recover_done_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == LPM_RECOVER && recoveryDone && !breakIrq) |=> stackStart && cpuClockEnable)
        else $error("recovery end missed");

    stop_watchdog_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == LPM_STOP |-> !watchdogRun)
        else $error("watchdog runs in stop");

    stop_out_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == LPM_STOP |-> !baseClockEnable && !crystalClockEnable && !cpuClockEnable)
        else $error("clock outputs live in stop");

    flag_clear_a: assert property (@(posedge mclk) disable iff (reset)
        (apbWrite && paddr == LPM_BREAK_STATUS_ADDR && !pwdata[LPM_BREAK_EXIT_BIT] && !breakIrq) |=> !breakExit_r)
        else $error("break exit flag not cleared");

    cause_keep_a: assert property (@(posedge mclk) disable iff (reset)
        (apbRead && paddr == LPM_RESET_CAUSE_ADDR && inBreakState && !breakClearEnable_r && !causeValid)
        |=> resetCause_r == $past(resetCause_r))
        else $error("cause cleared while protected");

    addr_fetch_a: assert property (@(posedge mclk) disable iff (reset)
        (causeValid && !causePowerOn && !causeAddressIsFetch) |=> !resetCause_r[LPM_CAUSE_ILLEGAL_ADDRESS_BIT])
        else $error("data access set address flag");

    power_on_a: assert property (@(posedge mclk) disable iff (reset)
        (causeValid && causePowerOn) |=> resetCause_r == LPM_RESET_CAUSE_RESET)
        else $error("power-on cause wrong");

    apb_ready_a: assert property (@(posedge mclk) disable iff (reset)
        (psel && penable && !pready) |=> pready)
        else $error("bus answer missing");

    apb_error_a: assert property (@(posedge mclk) disable iff (reset)
        (psel && penable && !pready && !addrHit) |=> pslverr)
        else $error("unmapped access not flagged");

    stack_pulse_a: assert property (@(posedge mclk) disable iff (reset)
        stackStart |=> !stackStart)
        else $error("stacking pulse too long");

    mask_pulse_a: assert property (@(posedge mclk) disable iff (reset)
        clearIntMask |=> !clearIntMask)
        else $error("mask pulse too long");
endmodule // lpm_control
`default_nettype wire

/* common/lpm_pkg.sv */
package lpm_pkg;
    // Register byte addresses on the APB
    localparam logic [15:0] LPM_BREAK_STATUS_ADDR = 16'hFE00;
    localparam logic [15:0] LPM_RESET_CAUSE_ADDR = 16'hFE01;
    localparam logic [15:0] LPM_BREAK_FLAG_CONTROL_ADDR = 16'hFE03;
    // Field positions
    localparam int LPM_BREAK_EXIT_BIT = 1;
    localparam int LPM_BREAK_CLEAR_ENABLE_BIT = 7;
    localparam int LPM_CAUSE_POWER_ON_BIT = 7;
    localparam int LPM_CAUSE_PIN_BIT = 6;
    localparam int LPM_CAUSE_WATCHDOG_BIT = 5;
    localparam int LPM_CAUSE_ILLEGAL_OPCODE_BIT = 4;
    localparam int LPM_CAUSE_ILLEGAL_ADDRESS_BIT = 3;
    localparam int LPM_CAUSE_USB_BIT = 2;
    // Reset values
    localparam logic [7:0] LPM_RESET_CAUSE_RESET = 8'h80;
    localparam logic [7:0] LPM_BREAK_STATUS_RESET = 8'h00;
    localparam logic [7:0] LPM_BREAK_FLAG_CONTROL_RESET = 8'h00;
    // Stop recovery lengths in crystal clock cycles
    localparam int LPM_RECOVERY_LONG = 4096;
    localparam int LPM_RECOVERY_SHORT = 32;
    localparam int LPM_COUNT_WIDTH = 13;
    typedef enum logic [1:0] {
        LPM_RUN,
        LPM_WAIT,
        LPM_STOP,
        LPM_RECOVER
    } lpm_state_e;
endpackage

/* dv/lpm_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
    input wire logic mclk,
    input wire logic stackStart,
    input wire logic cpuClockEnable,
    output logic waitInstr,
    output logic stopInstr,
    output logic moduleIrq,
    output logic breakIrq
);
    // Idle CPU: no instruction, no wake source
    initial {waitInstr, stopInstr, moduleIrq, breakIrq} = 4'h0;
    // One-cycle wait or stop instruction pulse
    task sleep(input logic stop);
        @(posedge mclk) {waitInstr, stopInstr} <= {!stop, stop};
        @(posedge mclk) {waitInstr, stopInstr} <= 2'h0;
    endtask
    // Hold a wake source until answered; n counts cycles
    task wake(input logic brk, output int n);
        @(posedge mclk) {moduleIrq, breakIrq} <= {!brk, brk};
        for (n = 1; n < 5000; n++) begin
            @(posedge mclk) #1;
            if ((brk ? cpuClockEnable : stackStart) === 1'h1) break;
        end
        {moduleIrq, breakIrq} <= 2'h0;
    endtask
endmodule // lpm_cpu_model
`default_nettype wire

/* dv/lpm_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lpm_control_tb;
    import lpm_pkg::*;
    localparam int LONG = 64;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, waitInstr, stopInstr, moduleIrq, breakIrq, stackStart;
    logic inBreakState, shortRecoverySelect, watchdogDisableOption, causeValid, clearIntMask, watchdogRun;
    logic cpuClockEnable, periphClockEnable, baseClockEnable, crystalClockEnable, breakExitStatus, breakClearAllowed;
    logic [6:0] cause, c;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_errors = 0, checks_done = 0, n;
    // Block under test, long recovery shortened
    lpm_control #(.RECOVERY_LONG(LONG)) lpm_control_inst (.mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .waitInstr(waitInstr), .stopInstr(stopInstr), .moduleIrq(moduleIrq), .breakIrq(breakIrq), .causeUsb(cause[0]),
        .inBreakState(inBreakState), .shortRecoverySelect(shortRecoverySelect), .causeValid(causeValid),
        .watchdogDisableOption(watchdogDisableOption), .causePowerOn(cause[6]), .causePin(cause[5]),
        .causeWatchdog(cause[4]), .causeIllegalOpcode(cause[3]), .causeIllegalAddress(cause[2]),
        .causeAddressIsFetch(cause[1]), .cpuClockEnable(cpuClockEnable), .periphClockEnable(periphClockEnable),
        .baseClockEnable(baseClockEnable), .crystalClockEnable(crystalClockEnable), .watchdogRun(watchdogRun),
        .clearIntMask(clearIntMask), .stackStart(stackStart), .breakExitStatus(breakExitStatus),
        .breakClearAllowed(breakClearAllowed));
    lpm_cpu_model lpm_cpu_model_inst (.mclk(mclk), .stackStart(stackStart), .cpuClockEnable(cpuClockEnable),
        .waitInstr(waitInstr), .stopInstr(stopInstr), .moduleIrq(moduleIrq), .breakIrq(breakIrq));
    // 40 MHz clock
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    // Compare and report a mismatch
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        n_errors += int'(g !== e);
        if (g !== e) $display("[ERR] %s exp %h got %h", nm, e, g);
    endtask
    // APB transfer; read data compared with d; FE02 is the unmapped gap
    task apb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge mclk) {paddr, pwrite, pwdata, psel} <= {a, w, w ? d : 32'h0, 1'h1};
        @(posedge mclk) penable <= 1'h1;
        for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge mclk);
        chk("resp", {1'h1, a == 16'hFE02}, {pready, pslverr});
        if (!w) chk("rdata", d, prdata);
        {psel, penable} <= 2'h0;
        if (i == 20) results();
    endtask
    // Present a reset cause for one cycle
    task setCause(input logic [6:0] v);
        @(posedge mclk) {cause, causeValid} <= {v, 1'h1};
        @(posedge mclk) causeValid <= 1'h0;
    endtask
    // Expected cause byte; power-on overrides the rest
    function automatic logic [31:0] expCause(input logic [6:0] v);
        return v[6] ? 32'h80 : {24'h0, 1'h0, v[5:3], v[2] & v[1], v[0], 2'h0};
    endfunction
    // Counts, verdict and end of run
    task results();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Stimulus and checks
    initial begin
        {reset, causeValid, cause} = {2'h3, 7'h40};
        {psel, penable, pwrite, inBreakState, shortRecoverySelect, watchdogDisableOption} = 6'h0;
        {paddr, pwdata} = 48'h0;
        void'($urandom(32'h57909226));
        repeat (5) @(posedge mclk);
        {reset, causeValid} <= 2'h0;
        apb(LPM_RESET_CAUSE_ADDR, 1'h0, 32'h80);
        apb(LPM_RESET_CAUSE_ADDR, 1'h0, 32'h0);
        for (int k = 0; k < 8; k++) begin
            c = (k < 2) ? 7'(4 + 2 * k) : 7'($urandom) & 7'h3F;
            setCause(c);
            apb(LPM_RESET_CAUSE_ADDR, 1'h0, expCause(c));
        end
        inBreakState <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            apb(LPM_BREAK_FLAG_CONTROL_ADDR, 1'h1, 32'(k * 128));
            apb(LPM_BREAK_FLAG_CONTROL_ADDR, 1'h0, 32'(k * 128));
            chk("clrOk", k, breakClearAllowed);
            setCause(7'h20);
            apb(LPM_RESET_CAUSE_ADDR, 1'h0, 32'h40);
            apb(LPM_RESET_CAUSE_ADDR, 1'h0, 32'(64 - 64 * k));
        end
        apb(16'hFE02, 1'h0, 32'h0);
        for (int k = 0; k < 2; k++) begin
            watchdogDisableOption <= k[0];
            lpm_cpu_model_inst.sleep(1'h0);
            #1;
            chk("wait", 2 + (k == 0), {cpuClockEnable, periphClockEnable, watchdogRun});
            lpm_cpu_model_inst.wake(k[0], n);
            @(posedge mclk) #1;
            chk("wake", 2 + k, {n == 1, breakExitStatus});
            if (n == 5000) results();
        end
        apb(LPM_BREAK_STATUS_ADDR, 1'h0, 32'h2);
        apb(LPM_BREAK_STATUS_ADDR, 1'h1, 32'h0);
        apb(LPM_BREAK_STATUS_ADDR, 1'h0, 32'h0);
        for (int k = 0; k < 3; k++) begin
            shortRecoverySelect <= (k == 0); // long delay kept for crystal use
            lpm_cpu_model_inst.sleep(1'h1);
            #1;
            chk("stop", 0, {cpuClockEnable, periphClockEnable, baseClockEnable, crystalClockEnable});
            chk("mask", 1, clearIntMask);
            repeat ($urandom_range(9, 2)) @(posedge mclk);
            lpm_cpu_model_inst.wake(k == 2, n);
            @(posedge mclk) #1;
            if (n == 5000) results();
            if (k < 2) chk("recov", 1, n - (k ? LONG : LPM_RECOVERY_SHORT) inside {[0:3]});
            else chk("brkStop", 3, {n == 1, breakExitStatus});
        end
        results();
    end
endmodule // lpm_control_tb
`default_nettype wire
